// >>> core/uhs_pkg.sv
// constants and carrier types for the host select and modem line block
package uhs_pkg;

  // ----------------------------------------------------------------------
  // register indices on the three select bits
  // ----------------------------------------------------------------------
  localparam logic [2:0] UHS_IDX_DLL = 3'h0;
  localparam logic [2:0] UHS_IDX_IER = 3'h1;
  localparam logic [2:0] UHS_IDX_LCR = 3'h3;
  localparam logic [2:0] UHS_IDX_MCR = 3'h4;
  localparam logic [2:0] UHS_IDX_MSR = 3'h6;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned UHS_LCR_DLAB = 7;
  localparam int unsigned UHS_IER_MODEM = 3;
  localparam int unsigned UHS_MCR_DTR = 0;
  localparam int unsigned UHS_MCR_RTS = 1;
  localparam int unsigned UHS_MCR_LOOP = 4;
  localparam int unsigned UHS_MCR_FLOW = 5;
  localparam int unsigned UHS_MSR_DCTS = 0;
  localparam int unsigned UHS_MSR_DDSR = 1;
  localparam int unsigned UHS_MSR_DDCD = 3;
  localparam int unsigned UHS_MSR_CTS = 4;
  localparam int unsigned UHS_MSR_DSR = 5;
  localparam int unsigned UHS_MSR_DCD = 7;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] UHS_RST_BYTE = 8'h00;
  localparam logic [15:0] UHS_RST_DIV = 16'h0001;
  localparam logic [15:0] UHS_DIV_OFF = 16'h0000;
  localparam int unsigned UHS_BAUD_MULT = 16;  // baud output runs at this multiple of bit rate

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cs_a;
    logic cs_b;
    logic cs_n;
    logic [2:0] idx;
  } uhs_sel_s;

  typedef struct packed {
    uhs_sel_s sel_hold;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [7:0] ier;
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [3:0] delta;
    logic [2:0] pin_prev;
    logic primed;
    logic wr_prev;
    logic rd_msr;
    logic [15:0] baud_cnt;
    logic baud_out;
    logic [7:0] dout;
    logic doe;
    logic drv_off;
    logic dtr_n;
    logic irq;
    logic tx_allow;
    logic auto_cts;
    logic auto_rts;
  } uhs_state_s;

endpackage : uhs_pkg

// >>> core/uhs_host_sel.sv
// host select, divisor, modem status and modem control logic of the serial element
`timescale 1ns/100ps

// Behaviour
// - the three select bits pick the register on every host read or write
// - strobe low: select and chip-select inputs pass straight through
// - strobe rising edge captures select and chip-selects, held while strobe high
// - baud output is the 16x clock, reference divided by the divisor latches
// - selected only with both high chip-selects high and the low one low
// - modem status read shows clear-to-send bit 4, set-ready bit 5, carrier bit 7
// - change flags bits 0, 1, 3 set by any level change since last read
// - modem interrupt on set-ready or carrier change; clear-to-send only without auto mode
// - in auto clear-to-send mode a new character starts only while it is active
// - driver-disable high except while the host reads
// - eight data lines, output enable low when not driving
// - terminal-ready output active low while its control bit is set and loopback bit 4 is clear
// - terminal-ready inactive on reset, in loopback, or with bit cleared
// - control bits 5 and 1 both set give full auto flow, bit 5 alone auto clear-to-send
module uhs_host_sel (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reg_sel_bit0,
  input wire logic reg_sel_bit1,
  input wire logic reg_sel_bit2,
  input wire logic chip_sel_hi_a,
  input wire logic chip_sel_hi_b,
  input wire logic chip_sel_low_n,
  input wire logic select_latch_strobe_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic transceiver_disable_out,
  output logic tx_16x_clock_out,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  output logic dtr_n,
  output logic modem_irq,
  output logic tx_start_allow,
  output logic auto_cts_active,
  output logic auto_rts_active
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  uhs_pkg::uhs_state_s st_q;
  uhs_pkg::uhs_state_s st_d;

  uhs_pkg::uhs_sel_s sel_live;
  uhs_pkg::uhs_sel_s sel_eff;
  logic selected;
  logic rd_now;
  logic wr_now;
  logic wr_take;
  logic rd_msr_now;
  logic [15:0] divisor;
  logic [3:0] delta_set;
  logic [7:0] msr_val;
  logic [7:0] rd_data;
  logic cts_act;

  // ----------------------------------------------------------------------
  // select path
  // ----------------------------------------------------------------------
  // live inputs gathered into one carrier
  assign sel_live = '{cs_a: chip_sel_hi_a, cs_b: chip_sel_hi_b, cs_n: chip_sel_low_n,
                      idx: {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0}};
  // transparent while the strobe is low, held copy once it has risen
  assign sel_eff = select_latch_strobe_n ? st_q.sel_hold : sel_live;
  assign selected = sel_eff.cs_a & sel_eff.cs_b & ~sel_eff.cs_n;
  assign rd_now = selected & ~host_rd_n;
  assign wr_now = selected & ~host_wr_n;
  // one write per strobe: only the first cycle of a low write level counts
  assign wr_take = wr_now & ~st_q.wr_prev;
  assign rd_msr_now = rd_now & (sel_eff.idx == uhs_pkg::UHS_IDX_MSR);
  assign divisor = {st_q.dlm, st_q.dll};
  assign cts_act = ~cts_n;

  // ----------------------------------------------------------------------
  // modem status
  // ----------------------------------------------------------------------
  // pin_prev holds {dcd_n, dsr_n, cts_n}; first cycle after reset only primes it
  always_comb begin
    delta_set = 4'h0;
    delta_set[uhs_pkg::UHS_MSR_DCTS] = st_q.primed & (cts_n ^ st_q.pin_prev[0]);
    delta_set[uhs_pkg::UHS_MSR_DDSR] = st_q.primed & (dsr_n ^ st_q.pin_prev[1]);
    delta_set[uhs_pkg::UHS_MSR_DDCD] = st_q.primed & (dcd_n ^ st_q.pin_prev[2]);
  end

  // ring indicator and its trailing-edge flag are not part of this block, read as zero
  always_comb begin
    msr_val = {4'h0, st_q.delta};
    msr_val[uhs_pkg::UHS_MSR_CTS] = ~cts_n;
    msr_val[uhs_pkg::UHS_MSR_DSR] = ~dsr_n;
    msr_val[uhs_pkg::UHS_MSR_DCD] = ~dcd_n;
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // index 0 and 1 fold onto the divisor while the latch-access bit is set
  always_comb begin
    rd_data = 8'h00;
    unique case (sel_eff.idx)
      uhs_pkg::UHS_IDX_DLL: rd_data = st_q.lcr[uhs_pkg::UHS_LCR_DLAB] ? st_q.dll : 8'h00;
      uhs_pkg::UHS_IDX_IER: rd_data = st_q.lcr[uhs_pkg::UHS_LCR_DLAB] ? st_q.dlm : st_q.ier;
      uhs_pkg::UHS_IDX_LCR: rd_data = st_q.lcr;
      uhs_pkg::UHS_IDX_MCR: rd_data = st_q.mcr;
      uhs_pkg::UHS_IDX_MSR: rd_data = msr_val;
      default: rd_data = 8'h00;  // data path registers live elsewhere
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // hold copy tracks the inputs while the strobe is low, freezes once high
    if (!select_latch_strobe_n) begin
      st_d.sel_hold = sel_live;
    end
    st_d.wr_prev = wr_now;

    // register writes on the first cycle of a selected write
    if (wr_take) begin
      unique case (sel_eff.idx)
        uhs_pkg::UHS_IDX_DLL: begin
          if (st_q.lcr[uhs_pkg::UHS_LCR_DLAB]) begin
            st_d.dll = data_in;
          end
        end
        uhs_pkg::UHS_IDX_IER: begin
          if (st_q.lcr[uhs_pkg::UHS_LCR_DLAB]) begin
            st_d.dlm = data_in;
          end else begin
            st_d.ier = data_in;
          end
        end
        uhs_pkg::UHS_IDX_LCR: st_d.lcr = data_in;
        uhs_pkg::UHS_IDX_MCR: st_d.mcr = data_in;
        default: st_d.lcr = st_q.lcr;  // status and data path indices ignore writes
      endcase
    end

    // change flags: a new change wins over the clear at the end of a status read
    st_d.pin_prev = {dcd_n, dsr_n, cts_n};
    st_d.primed = 1'b1;
    st_d.rd_msr = rd_msr_now;
    if (st_q.rd_msr && !rd_msr_now) begin
      st_d.delta = delta_set;
    end else begin
      st_d.delta = st_q.delta | delta_set;
    end

    // baud divider: one reference cycle high every divisor cycles; zero stops it
    if (divisor == uhs_pkg::UHS_DIV_OFF) begin
      st_d.baud_cnt = 16'h0000;
      st_d.baud_out = 1'b0;
    end else if (st_q.baud_cnt == 16'h0000 || st_q.baud_cnt >= divisor) begin
      st_d.baud_cnt = 16'(divisor - 16'h0001);
      st_d.baud_out = 1'b1;
    end else begin
      st_d.baud_cnt = 16'(st_q.baud_cnt - 16'h0001);
      st_d.baud_out = 1'b0;
    end

    // host bus drive: registered, so data appears one cycle after the read begins
    st_d.dout = rd_now ? rd_data : 8'h00;
    st_d.doe = rd_now;
    st_d.drv_off = ~rd_now;

    // modem control outputs
    st_d.dtr_n = ~(st_q.mcr[uhs_pkg::UHS_MCR_DTR] &
                   ~st_q.mcr[uhs_pkg::UHS_MCR_LOOP]);
    st_d.auto_cts = st_q.mcr[uhs_pkg::UHS_MCR_FLOW];
    st_d.auto_rts = st_q.mcr[uhs_pkg::UHS_MCR_FLOW] & st_q.mcr[uhs_pkg::UHS_MCR_RTS];
    // transmitter may begin a character only while clear-to-send is active in auto mode
    st_d.tx_allow = ~st_q.mcr[uhs_pkg::UHS_MCR_FLOW] | cts_act;
    st_d.irq = st_q.ier[uhs_pkg::UHS_IER_MODEM] &
               (st_q.delta[uhs_pkg::UHS_MSR_DDSR] | st_q.delta[uhs_pkg::UHS_MSR_DDCD] |
                (st_q.delta[uhs_pkg::UHS_MSR_DCTS] &
                 ~st_q.mcr[uhs_pkg::UHS_MCR_FLOW]));
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // clock enable low freezes everything, including the baud divider
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.sel_hold <= '{cs_a: 1'b0, cs_b: 1'b0, cs_n: 1'b1, idx: 3'h0};
      st_q.dll <= uhs_pkg::UHS_RST_DIV[7:0];
      st_q.dlm <= uhs_pkg::UHS_RST_DIV[15:8];
      st_q.ier <= uhs_pkg::UHS_RST_BYTE;
      st_q.lcr <= uhs_pkg::UHS_RST_BYTE;
      st_q.mcr <= uhs_pkg::UHS_RST_BYTE;
      st_q.pin_prev <= 3'h7;
      st_q.drv_off <= 1'b1;
      st_q.dtr_n <= 1'b1;
      st_q.tx_allow <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign data_out = st_q.dout;
  assign data_oe = st_q.doe;
  assign transceiver_disable_out = st_q.drv_off;
  assign tx_16x_clock_out = st_q.baud_out;
  assign dtr_n = st_q.dtr_n;
  assign modem_irq = st_q.irq;
  assign tx_start_allow = st_q.tx_allow;
  assign auto_cts_active = st_q.auto_cts;
  assign auto_rts_active = st_q.auto_rts;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // disable must be the exact inverse of the read drive, both ways
  property p_drv_off_vs_read;
    transceiver_disable_out == !data_oe;
  endproperty
  a_drv_off_vs_read: assert property (p_drv_off_vs_read) else $error("bad disable level");

  property p_live_select;
    clk_en && !select_latch_strobe_n && chip_sel_hi_a && chip_sel_hi_b && !chip_sel_low_n
      && !host_rd_n |=> data_oe;
  endproperty
  a_live_select: assert property (p_live_select) else $error("live select not honoured");

  property p_cs_gate;
    clk_en && !select_latch_strobe_n && !chip_sel_hi_a |=> !data_oe;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("drove bus while deselected");

  property p_hold_stable;
    clk_en && select_latch_strobe_n |=> $stable(st_q.sel_hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("held select changed");

  property p_dtr_active;
    clk_en && st_q.mcr[uhs_pkg::UHS_MCR_DTR] && !st_q.mcr[uhs_pkg::UHS_MCR_LOOP] |=> !dtr_n;
  endproperty
  a_dtr_active: assert property (p_dtr_active) else $error("terminal ready not active");

  property p_dtr_loop;
    clk_en && st_q.mcr[uhs_pkg::UHS_MCR_LOOP] |=> dtr_n;
  endproperty
  a_dtr_loop: assert property (p_dtr_loop) else $error("terminal ready in loopback");

  property p_cts_delta;
    clk_en && st_q.primed && (cts_n != st_q.pin_prev[0]) |=> st_q.delta[uhs_pkg::UHS_MSR_DCTS];
  endproperty
  a_cts_delta: assert property (p_cts_delta) else $error("clear-to-send change lost");

  property p_dsr_irq;
    clk_en && st_q.ier[uhs_pkg::UHS_IER_MODEM] && st_q.delta[uhs_pkg::UHS_MSR_DDSR] |=> modem_irq;
  endproperty
  a_dsr_irq: assert property (p_dsr_irq) else $error("set-ready change gave no interrupt");

  property p_auto_cts_gate;
    clk_en && st_q.mcr[uhs_pkg::UHS_MCR_FLOW] && cts_n |=> !tx_start_allow;
  endproperty
  a_auto_cts_gate: assert property (p_auto_cts_gate) else $error("transmit open, cts off");

  property p_auto_rts;
    clk_en && st_q.mcr[uhs_pkg::UHS_MCR_FLOW] && st_q.mcr[uhs_pkg::UHS_MCR_RTS]
      |=> auto_rts_active;
  endproperty
  a_auto_rts: assert property (p_auto_rts) else $error("full auto flow not enabled");

  // interrupt gating: carrier always counts, clear-to-send is muted in auto mode
  property p_dcd_irq;
    clk_en && st_q.ier[uhs_pkg::UHS_IER_MODEM] && st_q.delta[uhs_pkg::UHS_MSR_DDCD] |=> modem_irq;
  endproperty
  a_dcd_irq: assert property (p_dcd_irq) else $error("carrier change gave no interrupt");

  property p_cts_quiet;
    clk_en && st_q.mcr[uhs_pkg::UHS_MCR_FLOW] && !st_q.delta[uhs_pkg::UHS_MSR_DDSR]
      && !st_q.delta[uhs_pkg::UHS_MSR_DDCD] |=> !modem_irq;
  endproperty
  a_cts_quiet: assert property (p_cts_quiet) else $error("cts change raised interrupt");

  // with no fresh change at the end of a status read every flag must be gone
  property p_msr_clear;
    clk_en && st_q.rd_msr && !rd_msr_now && (delta_set == 4'h0) |=> (st_q.delta == 4'h0);
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("change flags kept after read");

  c_msr_read: cover property (clk_en && st_q.rd_msr && !rd_msr_now);
  c_div_write: cover property (wr_take && st_q.lcr[uhs_pkg::UHS_LCR_DLAB]);
  c_irq_rise: cover property ($rose(modem_irq));
  c_held_select: cover property (select_latch_strobe_n && data_oe);

endmodule // uhs_host_sel

// >>> sim/uhs_host_model.sv
// host processor model driving the select, strobe and data lines
`timescale 1ns/100ps
module uhs_host_model (
  input wire logic mclk,
  output logic [2:0] idx,
  output logic [2:0] cs,
  output logic strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic oe,
  input wire logic drv_off
);
  // idle: deselected; stale lines are inverted so old values never match by luck
  initial begin
    idx = 3'h7;
    cs = 3'h1;
    strobe_n = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    wdata = 8'hA5;
  end
  // present an index and selection, then raise the strobe to have them held
  task automatic latch(input logic [2:0] i);
    @(posedge mclk);
    idx <= i;
    cs <= 3'h6;
    @(posedge mclk);
    strobe_n <= 1'b1;
  endtask
  // one access held over two edges; with hold set the live lines show junk
  task automatic xfer(input bit rd, input bit hold, input logic [2:0] i, input logic [7:0] d,
                      input logic [2:0] c, output logic [7:0] q, output logic [1:0] st);
    @(posedge mclk);
    idx <= hold ? ~i : i;
    cs <= hold ? 3'h1 : c;
    rd_n <= !rd;
    wr_n <= rd;
    wdata <= d;
    @(posedge mclk);
    @(negedge mclk);
    q = rdata;
    st = {oe, drv_off};
    @(posedge mclk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    cs <= 3'h1;
    idx <= ~idx;
    wdata <= ~d;
    strobe_n <= 1'b0;
  endtask
endmodule // uhs_host_model

// >>> sim/tb_uhs_host_sel.sv
// self-checking bench for the host select and modem line block
`timescale 1ns/100ps
module tb_uhs_host_sel;
  logic mclk, rst_b, cts_n, dsr_n, dcd_n, strobe_n, rd_n, wr_n;
  logic oe, drv_off, baud, dtr_n, irq, allow, acts, arts, en;
  logic [2:0] idx, cs;
  logic [7:0] wdata, rdata, q;
  logic [1:0] st;
  int fail_count, tests_run, n;
  // ------------------------------------------------------------------
  // instances
  // ------------------------------------------------------------------
  uhs_host_sel dut_u (.mclk(mclk), .rst_b(rst_b), .clk_en(en), .reg_sel_bit0(idx[0]),
    .reg_sel_bit1(idx[1]), .reg_sel_bit2(idx[2]), .chip_sel_hi_a(cs[2]), .chip_sel_hi_b(cs[1]),
    .chip_sel_low_n(cs[0]), .select_latch_strobe_n(strobe_n), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .data_in(wdata), .data_out(rdata), .data_oe(oe),
    .transceiver_disable_out(drv_off), .tx_16x_clock_out(baud), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .dtr_n(dtr_n), .modem_irq(irq), .tx_start_allow(allow),
    .auto_cts_active(acts), .auto_rts_active(arts));
  uhs_host_model host_u (.mclk(mclk), .idx(idx), .cs(cs), .strobe_n(strobe_n), .rd_n(rd_n),
    .wr_n(wr_n), .wdata(wdata), .rdata(rdata), .oe(oe), .drv_off(drv_off));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cb(string nm, logic seen, logic exp);
    chk(nm, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic settle(int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic wr(logic [2:0] i, logic [7:0] d);
    host_u.xfer(1'b0, 1'b0, i, d, 3'h6, q, st);
  endtask
  task automatic rd(logic [2:0] i);
    host_u.xfer(1'b1, 1'b0, i, 8'h00, 3'h6, q, st);
  endtask
  // pin change lands in the flags one edge later, in the interrupt two
  task automatic pins(logic c, logic s, logic d);
    @(posedge mclk);
    cts_n <= c;
    dsr_n <= s;
    dcd_n <= d;
    settle(3);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    cb("dtr idle", dtr_n, 1'b1);
    cb("disable idle", drv_off, 1'b1);
    cb("oe idle", oe, 1'b0);
    rd(uhs_pkg::UHS_IDX_MSR);
    chk("msr quiet", q, 8'h00);
    chk("read drive", {6'h00, st}, 8'h02);
    settle(1);
    cb("disable after", drv_off, 1'b1);
  endtask
  task automatic t_mcr();
    wr(uhs_pkg::UHS_IDX_MCR, 8'h01);
    settle(1);
    cb("dtr on", dtr_n, 1'b0);
    rd(uhs_pkg::UHS_IDX_MCR);
    chk("mcr back", q, 8'h01);
    wr(uhs_pkg::UHS_IDX_MCR, 8'h11);
    settle(1);
    cb("dtr loop", dtr_n, 1'b1);
    wr(uhs_pkg::UHS_IDX_MCR, 8'h01);
    wr(uhs_pkg::UHS_IDX_MCR, 8'h00);
    settle(1);
    cb("dtr clear", dtr_n, 1'b1);
  endtask
  // each pattern leaves exactly one chip-select inactive
  task automatic t_select();
    logic [2:0] pat [3] = '{3'h2, 3'h4, 3'h7};
    foreach (pat[k]) begin
      host_u.xfer(1'b0, 1'b0, uhs_pkg::UHS_IDX_MCR, 8'h01, pat[k], q, st);
      settle(1);
      cb("deselected wr", dtr_n, 1'b1);
      host_u.xfer(1'b1, 1'b0, uhs_pkg::UHS_IDX_MCR, 8'h00, pat[k], q, st);
      cb("deselected rd", st[1], 1'b0);
    end
  endtask
  task automatic t_status();
    pins(1'b0, 1'b0, 1'b0);
    rd(uhs_pkg::UHS_IDX_MSR);
    chk("msr all", q, 8'hBB);
    rd(uhs_pkg::UHS_IDX_MSR);
    chk("msr cleared", q, 8'hB0);
  endtask
  task automatic t_irq();
    logic [2:0] pv [3] = '{3'h2, 3'h3, 3'h7};
    logic [7:0] ms [3] = '{8'h92, 8'h18, 8'h01};
    wr(uhs_pkg::UHS_IDX_IER, 8'h08);
    foreach (pv[k]) begin
      pins(pv[k][2], pv[k][1], pv[k][0]);
      cb("irq up", irq, 1'b1);
      rd(uhs_pkg::UHS_IDX_MSR);
      chk("msr delta", q, ms[k]);
      settle(2);
      cb("irq down", irq, 1'b0);
    end
  endtask
  task automatic t_auto();
    wr(uhs_pkg::UHS_IDX_MCR, 8'h20);
    settle(1);
    cb("auto cts", acts, 1'b1);
    cb("auto rts", arts, 1'b0);
    cb("gate shut", allow, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    cb("gate open", allow, 1'b1);
    cb("no cts irq", irq, 1'b0);
    rd(uhs_pkg::UHS_IDX_MSR);
    chk("msr auto", q, 8'h11);
    wr(uhs_pkg::UHS_IDX_MCR, 8'h22);
    settle(1);
    cb("full auto", arts, 1'b1);
    wr(uhs_pkg::UHS_IDX_MCR, 8'h00);
  endtask
  task automatic t_latch();
    host_u.latch(uhs_pkg::UHS_IDX_MCR);
    host_u.xfer(1'b0, 1'b1, uhs_pkg::UHS_IDX_MCR, 8'h01, 3'h6, q, st);
    settle(1);
    cb("held select", dtr_n, 1'b0);
    wr(uhs_pkg::UHS_IDX_MCR, 8'h00);
  endtask
  // divisor of three: ten pulses in any thirty consecutive cycles
  task automatic t_baud();
    wr(uhs_pkg::UHS_IDX_LCR, 8'h80);
    wr(uhs_pkg::UHS_IDX_DLL, 8'h03);
    wr(uhs_pkg::UHS_IDX_IER, 8'h00);
    wr(uhs_pkg::UHS_IDX_LCR, 8'h00);
    n = 0;
    repeat (30) begin
      @(negedge mclk);
      n += (baud === 1'b1) ? 1 : 0;
    end
    chk("baud pulses", 8'(n), 8'h0A);
    rd(uhs_pkg::UHS_IDX_IER);
    chk("ier kept", q, 8'h08);
  endtask
  // enable low freezes the pin history, so a change only counts once it is high again
  task automatic t_freeze();
    @(posedge mclk);
    en <= 1'b0;
    pins(1'b0, 1'b0, 1'b1);
    cb("frozen irq", irq, 1'b0);
    @(posedge mclk);
    en <= 1'b1;
    settle(3);
    cb("thawed irq", irq, 1'b1);
    rd(uhs_pkg::UHS_IDX_MSR);
    chk("msr thawed", q, 8'h32);
  endtask
  // ------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst_b = 1'b0;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    dcd_n = 1'b1;
    en = 1'b1;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    settle(1);
    t_reset();
    t_mcr();
    t_select();
    t_status();
    t_irq();
    t_auto();
    t_latch();
    t_baud();
    t_freeze();
    wrap_up();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule // tb_uhs_host_sel
